// ### hw/srx_consts.vh
/*
 Constants of the serial receiver: register addresses, field positions,
 reset values and sampling points. Assumes nothing beyond inclusion.
*/
`ifndef SRX_CONSTS_VH
`define SRX_CONSTS_VH
// Register addresses on the plain register port
`define SRX_ADDR_STATUS 3'h0
`define SRX_ADDR_DATA 3'h1
`define SRX_ADDR_CTRL1 3'h2
`define SRX_ADDR_CTRL2 3'h3
`define SRX_ADDR_BAUD 3'h4
`define SRX_ADDR_RXEXT 3'h5
`define SRX_ADDR_TXEXT 3'h6
// Status register fields
`define SRX_ST_FULL 5
`define SRX_ST_IDLE 4
`define SRX_ST_OVR 3
`define SRX_ST_NOISE 2
`define SRX_ST_FRAME 1
`define SRX_ST_PAR 0
// Control register one fields
`define SRX_C1_NINTH 7
`define SRX_C1_WLEN 4
`define SRX_C1_WAKE 3
`define SRX_C1_PON 2
`define SRX_C1_PSENSE 1
`define SRX_C1_PIE 0
// Control register two fields
`define SRX_C2_RIE 5
`define SRX_C2_IDLE_IRQ_EN 4
`define SRX_C2_RXON 2
`define SRX_C2_MUTE 1
// Baud rate register fields
`define SRX_BR_PRE_HI 7
`define SRX_BR_PRE_LO 6
`define SRX_BR_TX_HI 5
`define SRX_BR_TX_LO 3
`define SRX_BR_RX_HI 2
`define SRX_BR_RX_LO 0
// Reset values
`define SRX_RST_BYTE 8'h00
// Common prescaler values
`define SRX_PR0 4'h1
`define SRX_PR1 4'h3
`define SRX_PR2 4'h4
`define SRX_PR3 4'hD
// Sample indices within a bit, counted from zero
`define SRX_SMP_E3 4'h2
`define SRX_SMP_E5 4'h4
`define SRX_SMP_E7 4'h6
`define SRX_SMP_8 4'h7
`define SRX_SMP_9 4'h8
`define SRX_SMP_10 4'h9
`define SRX_SMP_LAST 4'hF
// Idle frame lengths in samples: ten or eleven bits of sixteen samples
`define SRX_IDLE_LEN8 8'hA0
`define SRX_IDLE_LEN9 8'hB0
`endif

// ### hw/srx_baud_gen.v
/*
 Baud sample tick generator: divides the core clock by the common
 prescaler, a power of two and an optional extended prescaler.
 Assumes settings stay stable while the divider runs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "srx_consts.vh"
module srx_baud_gen #(
   parameter CW = 19
) (
   input wire core_clk,
   input wire arst_n,
   input wire runEn,
   input wire [1:0] prescaleSel,
   input wire [2:0] rateDiv,
   input wire [7:0] extPrescale,
   output reg sampleTick
);
   // Common prescaler lookup
   function [3:0] prescaleVal;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: prescaleVal = `SRX_PR0;
            2'h1: prescaleVal = `SRX_PR1;
            2'h2: prescaleVal = `SRX_PR2;
            default: prescaleVal = `SRX_PR3;
         endcase
      end
   endfunction

   wire [7:0] extEff;
   wire [11:0] baseDiv;
   wire [CW-1:0] divisor;
   reg [CW-1:0] cnt_reg;

   // Zero in the extended prescaler keeps the conventional rate
   assign extEff = (extPrescale == 8'h00) ? 8'h01 : extPrescale; // [RULE13]
   assign baseDiv = {8'h00, prescaleVal(prescaleSel)} * {4'h0, extEff}; // [RULE11]
   assign divisor = {{(CW-12){1'b0}}, baseDiv} << rateDiv; // [RULE11]

   // Divider counter, one tick per sixteenth of a bit
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= {CW{1'b0}};
         sampleTick <= 1'b0;
      end else if (!runEn) begin
         cnt_reg <= {CW{1'b0}};
         sampleTick <= 1'b0;
      end else if (cnt_reg >= divisor - {{(CW-1){1'b0}}, 1'b1}) begin
         cnt_reg <= {CW{1'b0}};
         sampleTick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
         sampleTick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### hw/srx_receiver.v
/*
 Serial receiver with baud generation, mute and wake-up, and parity.
 Holds the register file, start-bit hunt, oversampled bit recovery,
 error flags and the interrupt request. Assumes one core clock, a
 receive pin from outside that domain and a one-cycle register port.
*/
// Local design decisions: the address map and strobed register access.
// Notes on behaviour
// [RULE1] Setting receiver-on starts the hunt for a start bit.
// [RULE2] Completed character loads buffer, sets full flag, interrupts if enabled and unmasked.
// [RULE3] Full flag clears by status access then data read, before next character ends.
// [RULE4] Idle frame sets the idle flag and interrupts if idle interrupt enabled.
// [RULE5] Character while full sets overrun, keeps buffer, overwrites shift register.
// [RULE6] Overrun, noise and framing flags clear by status access then data read.
// [RULE7] Data bit valid only if samples 8, 9, 10 agree; start adds edge checks.
// [RULE8] Noise flag rises with full flag, data still moves, no own interrupt.
// [RULE9] False start discards frame; noise held internally until next valid frame.
// [RULE10] Missing stop bit or break sets framing flag with full flag.
// [RULE11] Rate is clock over 16, common prescaler, and power-of-two divider.
// [RULE12] Software leaves baud settings alone while enabled.
// [RULE13] Nonzero extended prescaler divides further; zero keeps conventional rate.
// [RULE14] While muted, no status bit sets and no receive interrupt.
// [RULE15] Wake by idle line when method clear, by address mark when set.
// [RULE16] Idle-line wake clears mute without setting the idle flag.
// [RULE17] Address mark: data MSB one clears mute and receives the word normally.
// [RULE18] Software avoids writing control register two while muted.
// [RULE19] Word length and parity select 8, 7+P, 9 or 8+P bits.
// [RULE20] Parity makes ones count even for sense 0, odd for sense 1.
// [RULE21] Transmit word has its MSB replaced by parity when enabled.
// [RULE22] Received parity mismatch sets parity flag, interrupts if enabled.
// [RULE23] Sixteen samples per bit, majority of 8th, 9th, 10th.
// [RULE24] In 9-bit mode the top received bit goes to the ninth-bit field.
// [RULE25] Data read returns buffer; buffer reloads only after full flag clears.
`timescale 1ns/1ps
`default_nettype none
`include "srx_consts.vh"
module srx_receiver (
   input wire core_clk,
   input wire arst_n,
   input wire [2:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWrStb,
   input wire regRdStb,
   output reg [7:0] regRdData,
   input wire rxPin,
   input wire cpuMaskFlag,
   output reg irqReq,
   output reg [8:0] txWord,
   output reg txWordStb,
   output reg txBitTick
);
   localparam ST_HUNT = 4'h1;
   localparam ST_START = 4'h2;
   localparam ST_DATA = 4'h4;
   localparam ST_STOP = 4'h8;

   // Parity bit over seven or eight low bits
   function parityOf;
      input [7:0] d;
      input wide;
      input sense;
      begin
         parityOf = (wide ? ^d : ^d[6:0]) ^ sense; // [RULE20]
      end
   endfunction

   // Majority of three samples
   function maj3;
      input a;
      input b;
      input c;
      begin
         maj3 = (a & b) | (a & c) | (b & c);
      end
   endfunction

   reg [7:0] ctrl1_reg;
   reg [7:0] ctrl2_reg;
   reg [7:0] baud_reg;
   reg [7:0] rxExt_reg;
   reg [7:0] txExt_reg;
   reg [7:0] rxBuffer_reg;
   reg rxNinth_reg;
   reg rxFull_reg;
   reg idle_reg;
   reg overrun_reg;
   reg noise_reg;
   reg frameErr_reg;
   reg parFail_reg;
   reg statusSeen_reg;
   reg pinMeta_reg;
   reg pinSync_reg;
   reg [3:0] state_reg;
   reg [3:0] smp_reg;
   reg [3:0] bitIdx_reg;
   reg [2:0] hist_reg;
   reg s8_reg;
   reg s9_reg;
   reg [8:0] shift_reg;
   reg frameNoise_reg;
   reg pendNoise_reg;
   reg stopBad_reg;
   reg done_reg;
   reg [7:0] idleCnt_reg;
   reg idleArmed_reg;
   reg idleEvt_reg;
   reg [3:0] txSub_reg;

   wire wordLen;
   wire wakeAddr;
   wire parOn;
   wire parSense;
   wire rxOn;
   wire muted;
   wire rxTick;
   wire txTick;
   wire [3:0] lastBit;
   wire [7:0] idleLen;
   wire dataMsb;
   wire wakeNow;
   wire accept;
   wire idleWake;
   wire setFull;
   wire setOvr;
   wire setIdle;
   wire parBad;
   wire clrSeq;
   wire curMaj;

   assign wordLen = ctrl1_reg[`SRX_C1_WLEN];
   assign wakeAddr = ctrl1_reg[`SRX_C1_WAKE];
   assign parOn = ctrl1_reg[`SRX_C1_PON];
   assign parSense = ctrl1_reg[`SRX_C1_PSENSE];
   assign rxOn = ctrl2_reg[`SRX_C2_RXON];
   assign muted = ctrl2_reg[`SRX_C2_MUTE];

   // Receive and transmit rate generators, separate dividers sharing the common prescaler
   srx_baud_gen #(.CW(19)) u_rxBaud (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .runEn(rxOn),
      .prescaleSel(baud_reg[`SRX_BR_PRE_HI:`SRX_BR_PRE_LO]),
      .rateDiv(baud_reg[`SRX_BR_RX_HI:`SRX_BR_RX_LO]),
      .extPrescale(rxExt_reg),
      .sampleTick(rxTick)
   );
   srx_baud_gen #(.CW(19)) u_txBaud (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .runEn(1'b1),
      .prescaleSel(baud_reg[`SRX_BR_PRE_HI:`SRX_BR_PRE_LO]),
      .rateDiv(baud_reg[`SRX_BR_TX_HI:`SRX_BR_TX_LO]),
      .extPrescale(txExt_reg),
      .sampleTick(txTick)
   );

   // Frame shape and completion decisions
   assign lastBit = wordLen ? 4'h8 : 4'h7; // [RULE19]
   assign idleLen = wordLen ? `SRX_IDLE_LEN9 : `SRX_IDLE_LEN8;
   assign dataMsb = wordLen ? (parOn ? shift_reg[7] : shift_reg[8])
                            : (parOn ? shift_reg[6] : shift_reg[7]); // [RULE17]
   assign wakeNow = muted & wakeAddr & dataMsb; // [RULE17]
   assign accept = done_reg & (~muted | wakeNow); // [RULE14]
   assign idleWake = idleEvt_reg & muted & ~wakeAddr; // [RULE15]
   assign setFull = accept & ~rxFull_reg; // [RULE2]
   assign setOvr = accept & rxFull_reg; // [RULE5]
   assign setIdle = idleEvt_reg & ~muted; // [RULE4]
   assign parBad = parOn & (parityOf(shift_reg[7:0], wordLen, parSense)
                  != (wordLen ? shift_reg[8] : shift_reg[7])); // [RULE22]
   assign clrSeq = regRdStb & (regAddr == `SRX_ADDR_DATA) & statusSeen_reg; // [RULE3]
   assign curMaj = maj3(s8_reg, s9_reg, pinSync_reg); // [RULE23]

   // Two-flop synchroniser for the receive pin
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pinMeta_reg <= 1'b1;
         pinSync_reg <= 1'b1;
      end else begin
         pinMeta_reg <= rxPin;
         pinSync_reg <= pinMeta_reg;
      end
   end

   // Oversampled frame recovery
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_HUNT;
         smp_reg <= 4'h0;
         bitIdx_reg <= 4'h0;
         hist_reg <= 3'h0;
         s8_reg <= 1'b0;
         s9_reg <= 1'b0;
         shift_reg <= 9'h000;
         frameNoise_reg <= 1'b0;
         pendNoise_reg <= 1'b0;
         stopBad_reg <= 1'b0;
         done_reg <= 1'b0;
         idleCnt_reg <= 8'h00;
         idleArmed_reg <= 1'b0;
         idleEvt_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         idleEvt_reg <= 1'b0;
         if (accept) begin
            pendNoise_reg <= 1'b0; // Held noise is shown with this frame when it sets the full flag, dropped on overrun
         end
         if (!rxOn) begin
            state_reg <= ST_HUNT;
            hist_reg <= 3'h0;
            idleCnt_reg <= 8'h00;
            idleArmed_reg <= 1'b1;
         end else if (rxTick) begin
            case (state_reg)
               ST_HUNT: begin
                  hist_reg <= {hist_reg[1:0], pinSync_reg};
                  if (pinSync_reg) begin
                     if (idleCnt_reg != 8'hFF) begin
                        idleCnt_reg <= idleCnt_reg + 8'h01;
                     end
                     if (idleArmed_reg && idleCnt_reg == idleLen - 8'h01) begin
                        idleEvt_reg <= 1'b1; // [RULE4]
                        idleArmed_reg <= 1'b0;
                     end
                  end else begin
                     idleCnt_reg <= 8'h00;
                     if (hist_reg == 3'h7) begin
                        state_reg <= ST_START; // [RULE1]
                        smp_reg <= 4'h1;
                        frameNoise_reg <= 1'b0;
                        shift_reg <= 9'h000;
                     end
                  end
               end
               ST_START: begin
                  smp_reg <= smp_reg + 4'h1;
                  if ((smp_reg == `SRX_SMP_E3 || smp_reg == `SRX_SMP_E5 ||
                       smp_reg == `SRX_SMP_E7) && pinSync_reg) begin
                     frameNoise_reg <= 1'b1; // [RULE7]
                  end
                  if (smp_reg == `SRX_SMP_8) begin
                     s8_reg <= pinSync_reg;
                  end
                  if (smp_reg == `SRX_SMP_9) begin
                     s9_reg <= pinSync_reg;
                  end
                  if (smp_reg == `SRX_SMP_10) begin
                     if (curMaj) begin
                        state_reg <= ST_HUNT; // [RULE9]
                        hist_reg <= 3'h0;
                        pendNoise_reg <= 1'b1; // [RULE9]
                     end else if (s8_reg | s9_reg | pinSync_reg) begin
                        frameNoise_reg <= 1'b1; // [RULE7]
                     end
                  end
                  if (smp_reg == `SRX_SMP_LAST) begin
                     state_reg <= ST_DATA;
                     bitIdx_reg <= 4'h0;
                  end
               end
               ST_DATA: begin
                  smp_reg <= smp_reg + 4'h1;
                  if (smp_reg == `SRX_SMP_8) begin
                     s8_reg <= pinSync_reg;
                  end
                  if (smp_reg == `SRX_SMP_9) begin
                     s9_reg <= pinSync_reg;
                  end
                  if (smp_reg == `SRX_SMP_10) begin
                     shift_reg[bitIdx_reg] <= curMaj; // [RULE23]
                     if (!(s8_reg == s9_reg && s9_reg == pinSync_reg)) begin
                        frameNoise_reg <= 1'b1; // [RULE7]
                     end
                  end
                  if (smp_reg == `SRX_SMP_LAST) begin
                     bitIdx_reg <= bitIdx_reg + 4'h1;
                     if (bitIdx_reg == lastBit) begin
                        state_reg <= ST_STOP; // [RULE19]
                     end
                  end
               end
               ST_STOP: begin
                  smp_reg <= smp_reg + 4'h1;
                  if (smp_reg == `SRX_SMP_8) begin
                     s8_reg <= pinSync_reg;
                  end
                  if (smp_reg == `SRX_SMP_9) begin
                     s9_reg <= pinSync_reg;
                  end
                  if (smp_reg == `SRX_SMP_10) begin
                     if (!(s8_reg == s9_reg && s9_reg == pinSync_reg)) begin
                        frameNoise_reg <= 1'b1; // [RULE7]
                     end
                     stopBad_reg <= ~curMaj; // [RULE10]
                     hist_reg <= curMaj ? 3'h7 : 3'h0; // Break needs ones first
                     done_reg <= 1'b1;
                     idleArmed_reg <= 1'b1;
                     idleCnt_reg <= 8'h00;
                     state_reg <= ST_HUNT;
                  end
               end
               default: begin
                  state_reg <= ST_HUNT;
               end
            endcase
         end
      end
   end

   // Status flags: a hardware set wins over the clearing sequence
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rxFull_reg <= 1'b0;
         idle_reg <= 1'b0;
         overrun_reg <= 1'b0;
         noise_reg <= 1'b0;
         frameErr_reg <= 1'b0;
         parFail_reg <= 1'b0;
         rxBuffer_reg <= `SRX_RST_BYTE;
         rxNinth_reg <= 1'b0;
         statusSeen_reg <= 1'b0;
      end else begin
         if (regRdStb && regAddr == `SRX_ADDR_STATUS) begin
            statusSeen_reg <= 1'b1;
         end else if (clrSeq) begin
            statusSeen_reg <= 1'b0;
         end
         rxFull_reg <= setFull | (rxFull_reg & ~clrSeq); // [RULE3]
         overrun_reg <= setOvr | (overrun_reg & ~clrSeq); // [RULE5] [RULE6]
         idle_reg <= setIdle | (idle_reg & ~clrSeq); // [RULE16]
         noise_reg <= (setFull & (frameNoise_reg | pendNoise_reg)) |
                      (noise_reg & ~clrSeq); // [RULE8] [RULE6]
         frameErr_reg <= (setFull & stopBad_reg) | (frameErr_reg & ~clrSeq); // [RULE10]
         parFail_reg <= (setFull & parBad) | (parFail_reg & ~clrSeq); // [RULE22]
         if (setFull) begin
            rxBuffer_reg <= shift_reg[7:0]; // [RULE25]
            rxNinth_reg <= wordLen & shift_reg[8]; // [RULE24]
         end
      end
   end

   // Register writes; hardware wake clears mute unless software writes it
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl1_reg <= `SRX_RST_BYTE;
         ctrl2_reg <= `SRX_RST_BYTE;
         baud_reg <= `SRX_RST_BYTE;
         rxExt_reg <= `SRX_RST_BYTE;
         txExt_reg <= `SRX_RST_BYTE;
         txWord <= 9'h000;
         txWordStb <= 1'b0;
      end else begin
         txWordStb <= 1'b0;
         if (regWrStb && regAddr == `SRX_ADDR_CTRL2) begin
            ctrl2_reg <= regWrData; // [RULE18]
         end else if (idleWake || (accept && wakeNow)) begin
            ctrl2_reg[`SRX_C2_MUTE] <= 1'b0; // [RULE16] [RULE17]
         end
         if (regWrStb) begin
            case (regAddr)
               `SRX_ADDR_CTRL1: ctrl1_reg <= {1'b0, regWrData[6:0]};
               `SRX_ADDR_BAUD: baud_reg <= regWrData; // [RULE12]
               `SRX_ADDR_RXEXT: rxExt_reg <= regWrData; // [RULE13]
               `SRX_ADDR_TXEXT: txExt_reg <= regWrData;
               `SRX_ADDR_DATA: begin
                  txWordStb <= 1'b1;
                  if (parOn && !wordLen) begin
                     txWord <= {1'b0, parityOf(regWrData, 1'b0, parSense),
                                regWrData[6:0]}; // [RULE21]
                  end else if (parOn) begin
                     txWord <= {parityOf(regWrData, 1'b1, parSense),
                                regWrData}; // [RULE21]
                  end else begin
                     txWord <= {1'b0, regWrData};
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Read data one cycle after the strobe, interrupt level, transmit bit tick
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         regRdData <= 8'h00;
         irqReq <= 1'b0;
         txSub_reg <= 4'h0;
         txBitTick <= 1'b0;
      end else begin
         regRdData <= 8'h00;
         if (regRdStb) begin
            case (regAddr)
               `SRX_ADDR_STATUS: regRdData <= {2'h0, rxFull_reg, idle_reg,
                  overrun_reg, noise_reg, frameErr_reg, parFail_reg};
               `SRX_ADDR_DATA: regRdData <= rxBuffer_reg; // [RULE25]
               `SRX_ADDR_CTRL1: regRdData <= {rxNinth_reg, ctrl1_reg[6:0]};
               `SRX_ADDR_CTRL2: regRdData <= ctrl2_reg;
               `SRX_ADDR_BAUD: regRdData <= baud_reg;
               `SRX_ADDR_RXEXT: regRdData <= rxExt_reg;
               `SRX_ADDR_TXEXT: regRdData <= txExt_reg;
               default: regRdData <= 8'h00;
            endcase
         end
         irqReq <= ~cpuMaskFlag & (
            ((rxFull_reg | overrun_reg) & ctrl2_reg[`SRX_C2_RIE]) |
            (idle_reg & ctrl2_reg[`SRX_C2_IDLE_IRQ_EN]) |
            (parFail_reg & ctrl1_reg[`SRX_C1_PIE])); // [RULE2] [RULE4] [RULE5] [RULE22]
         txBitTick <= 1'b0;
         if (txTick) begin
            txSub_reg <= txSub_reg + 4'h1;
            txBitTick <= (txSub_reg == `SRX_SMP_LAST); // [RULE11]
         end
      end
   end
endmodule
`default_nettype wire

// ### testbench/srx_checker.sv
/*
 Port checker for the serial receiver.
 Assumes one clock and transmit baud settings left at their reset value.
*/
`timescale 1ns/1ps
`default_nettype none
`include "srx_consts.vh"
module srx_checker (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   input wire logic [7:0] regRdData,
   input wire logic rxPin,
   input wire logic cpuMaskFlag,
   input wire logic irqReq,
   input wire logic [8:0] txWord,
   input wire logic txWordStb,
   input wire logic txBitTick
);
   logic [7:0] c1_reg;
   logic [7:0] c2_reg;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // Shadow of the control registers as software wrote them
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         c1_reg <= 8'h00;
         c2_reg <= 8'h00;
      end else if (regWrStb && regAddr == `SRX_ADDR_CTRL1) begin
         c1_reg <= regWrData;
      end else if (regWrStb && regAddr == `SRX_ADDR_CTRL2) begin
         c2_reg <= regWrData;
      end
   end
   AST_RD_QUIET: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
      else $error("read data not zero outside read cycle");
   AST_MASK: assert property ($past(cpuMaskFlag) |-> !irqReq)
      else $error("interrupt raised while masked");
   AST_IRQ_EN: assert property ($rose(irqReq) |->
      $past(c2_reg[`SRX_C2_RIE] | c2_reg[`SRX_C2_IDLE_IRQ_EN] | c1_reg[`SRX_C1_PIE]))
      else $error("interrupt without any enable");
   AST_TX_STB: assert property (txWordStb == $past(regWrStb && regAddr == `SRX_ADDR_DATA))
      else $error("transmit word strobe misplaced");
   AST_TX_PAR7: assert property (txWordStb && c1_reg[`SRX_C1_PON]
      && !c1_reg[`SRX_C1_WLEN] |-> txWord[7] == (^txWord[6:0] ^ c1_reg[`SRX_C1_PSENSE]))
      else $error("parity of seven bit word wrong");
   AST_TX_PAR8: assert property (txWordStb && c1_reg[`SRX_C1_PON]
      && c1_reg[`SRX_C1_WLEN] |-> txWord[8] == (^txWord[7:0] ^ c1_reg[`SRX_C1_PSENSE]))
      else $error("parity of eight bit word wrong");
   AST_TICK_PER: assert property (txBitTick |-> ##16 txBitTick)
      else $error("bit tick period not sixteen");
   AST_TICK_GAP: assert property (txBitTick |=> !txBitTick [*8])
      else $error("bit tick too close");
endmodule
bind srx_receiver srx_checker u_srx_checker (
   .core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
   .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .rxPin(rxPin),
   .cpuMaskFlag(cpuMaskFlag), .irqReq(irqReq), .txWord(txWord), .txWordStb(txWordStb),
   .txBitTick(txBitTick)
);
`default_nettype wire

// ### testbench/srx_tx_model.sv
/*
 Far-end serial transmitter model on the receive line.
 Assumes one line cycle per core clock and an idle-high line.
*/
`timescale 1ns/1ps
`default_nettype none
module srx_tx_model (
   input wire logic core_clk,
   output logic txLine
);
   initial txLine = 1'b1;
   // Sends a frame LSB first, inverting sample slot 8 of bit g
   task automatic sendFrame(input logic [11:0] f, input int len, input int cpb, input int g);
      for (int i = 0; i < len; i++) begin
         for (int c = 0; c < cpb; c++) begin
            @(posedge core_clk);
            txLine <= (i == g && c == 8) ? ~f[i] : f[i];
         end
      end
      @(posedge core_clk);
      txLine <= 1'b1;
   endtask
   // Short low pulse that looks like a false start
   task automatic lowPulse(input int n);
      repeat (n) begin
         @(posedge core_clk);
         txLine <= 1'b0;
      end
      @(posedge core_clk);
      txLine <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ### testbench/srx_receiver_tb_top.sv
/*
 Testbench of the serial receiver: register tasks and frame scenarios.
 Assumes the transmitter model on the receive line and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module srx_receiver_tb_top;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWrData = 8'h00;
   logic regWrStb = 1'b0, regRdStb = 1'b0, cpuMaskFlag = 1'b0;
   logic [7:0] regRdData;
   logic [8:0] txWord;
   logic irqReq, txWordStb, txBitTick, rxPin;
   int num_errors = 0;
   int checked = 0;
   // Clock of 20 ns
   always #10 core_clk = ~core_clk;
   srx_receiver u_srx_receiver (
      .core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .rxPin(rxPin),
      .cpuMaskFlag(cpuMaskFlag), .irqReq(irqReq), .txWord(txWord), .txWordStb(txWordStb),
      .txBitTick(txBitTick)
   );
   srx_tx_model u_srx_tx_model (.core_clk(core_clk), .txLine(rxPin));
   // Comparison and bus tasks
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge core_clk);
      regWrStb <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge core_clk);
      regRdStb <= 1'b0;
      #1 chk(regRdData, exp);
   endtask
   task automatic clr(input logic [7:0] st, input logic [7:0] d);
      rd(3'h0, st);
      rd(3'h1, d);
   endtask
   task automatic irqAfter(input logic m, input logic exp);
      @(posedge core_clk);
      cpuMaskFlag <= m;
      repeat (2) @(posedge core_clk);
      #1 chk(irqReq, exp);
   endtask
   task automatic tx(input logic [8:0] d, input logic stp, input logic nine, input int g,
      input int cpb);
      repeat (8) @(posedge core_clk); // Idle line so the hunt sees three ones first
      if (nine) u_srx_tx_model.sendFrame({1'b0, stp, d, 1'b0}, 11, cpb, g);
      else u_srx_tx_model.sendFrame({2'b00, stp, d[7:0], 1'b0}, 10, cpb, g);
   endtask
   task automatic tally_and_finish;
      if (num_errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
      wr(3'h3, 8'h24);
      tx(9'h0A5, 1'h1, 1'h0, -1, 16);
      chk(irqReq, 1'h1);
      clr(8'h20, 8'hA5);
      rd(3'h0, 8'h00);
      irqAfter(1'h0, 1'h0);
      tx(9'h011, 1'h1, 1'h0, -1, 16);
      tx(9'h022, 1'h1, 1'h0, -1, 16);
      clr(8'h28, 8'h11);
      rd(3'h0, 8'h00);
      tx(9'h03C, 1'h1, 1'h0, 3, 16);
      clr(8'h24, 8'h3C);
      tx(9'h05A, 1'h0, 1'h0, -1, 16);
      clr(8'h22, 8'h5A);
      tx(9'h000, 1'h0, 1'h0, -1, 16);
      clr(8'h22, 8'h00);
      u_srx_tx_model.lowPulse(8);
      repeat (40) @(posedge core_clk);
      rd(3'h0, 8'h00);
      tx(9'h077, 1'h1, 1'h0, -1, 16);
      clr(8'h24, 8'h77);
      wr(3'h2, 8'h05);
      tx(9'h035, 1'h1, 1'h0, -1, 16);
      clr(8'h20, 8'h35);
      tx(9'h0B5, 1'h1, 1'h0, -1, 16);
      clr(8'h21, 8'hB5);
      wr(3'h2, 8'h07);
      wr(3'h1, 8'h00);
      #1 chk(txWord[7:0], 8'h80);
      wr(3'h2, 8'h14);
      wr(3'h1, 8'h01);
      #1 chk(txWord, 9'h101);
      wr(3'h2, 8'h10);
      tx(9'h1C3, 1'h1, 1'h1, -1, 16);
      rd(3'h2, 8'h90);
      irqAfter(1'h1, 1'h0);
      irqAfter(1'h0, 1'h1);
      clr(8'h20, 8'hC3);
      wr(3'h2, 8'h08);
      wr(3'h3, 8'h26);
      tx(9'h012, 1'h1, 1'h0, -1, 16);
      rd(3'h0, 8'h00);
      tx(9'h092, 1'h1, 1'h0, -1, 16);
      rd(3'h3, 8'h24);
      clr(8'h20, 8'h92);
      wr(3'h2, 8'h00);
      wr(3'h3, 8'h00);
      wr(3'h3, 8'h36);
      repeat (200) @(posedge core_clk);
      rd(3'h3, 8'h34);
      rd(3'h0, 8'h00);
      tx(9'h044, 1'h1, 1'h0, -1, 16);
      clr(8'h20, 8'h44);
      repeat (200) @(posedge core_clk);
      irqAfter(1'h0, 1'h1);
      clr(8'h10, 8'h44);
      wr(3'h3, 8'h00);
      wr(3'h5, 8'h02);
      rd(3'h5, 8'h02);
      wr(3'h3, 8'h24);
      tx(9'h06B, 1'h1, 1'h0, -1, 32);
      clr(8'h20, 8'h6B);
      tally_and_finish();
   end
endmodule
`default_nettype wire
